// >>> logic/uies_core.sv
// Functional notes
// - FIFO mode receive interrupt follows level at or above trigger.
// - Data ready flag sets on character into FIFO, clears when empty.
// - Line status bit 1 overrun; bits 2-4 errors of head byte.
// - Bit 5 holding empty, bit 6 all transmit empty, bit 7 FIFO error.
// - Mask bit 0 enables receive ready: holding full or trigger reached.
// - Mask bit 1 enables transmit ready; enabling while empty fires at once.
// - Mask bit 2 enables line status interrupt from status bits 1-4.
// - Mask bit 3 enables modem interrupt from delta bits 0-3.
// - Mask bits 4-7 writable only with enhanced enable; all reset 0.
// - CTS and RTS rising edges in auto flow raise flow interrupt.
// - Time-out from four characters plus twelve bits; receive read clears.
// - Line read, drained receive data, modem read clear their interrupts.
// - Transmit ready set by trigger or empty; source read or write clears.
// - Xoff clears on source read or Xon; special char on next char.
// - Flow change interrupts clear on modem status read.
// - Source read shows only highest pending; others stay queued.
// - Codes: line 000110, time-out 001100, rx 000100, tx 000010.
// - Codes: modem 000000, xoff 010000, flow 100000, none 000001.
// - Source bit 0 low while pending, high otherwise and at reset.
// - Source bits 4 and 5 active only with enhanced enable.
// - Source bits 7:6 read 11 with FIFOs enabled, 00 otherwise.
// - FIFO mode only while FIFO control bit 0 is set.
`timescale 1ns/10ps
`default_nettype none
`include "uies_defs.svh"

module uies_core (
    input  wire logic              clock,
    input  wire logic              sys_rst,
    input  wire uies_pkg::uies_addr_t addr,
    input  wire uies_pkg::uies_data_t wr_data,
    input  wire logic              wr_stb,
    input  wire logic              rd_stb,
    output var  uies_pkg::uies_data_t rd_data,
    input  wire logic              rx_char_in,
    input  wire logic              rx_fifo_empty,
    input  wire logic              rx_at_trigger,
    input  wire logic              rx_overrun,
    input  wire logic [2:0]        rx_head_error,
    input  wire logic              rx_any_error,
    input  wire logic              tx_hold_empty,
    input  wire logic              tx_below_trigger,
    input  wire logic              tx_all_empty,
    input  wire logic [3:0]        modem_delta,
    input  wire logic [3:0]        modem_inputs,
    input  wire logic              bit_tick,
    input  wire logic              xoff_match,
    input  wire logic              xon_match,
    input  wire logic              special_match,
    input  wire logic              cts_level,
    input  wire logic              rts_level,
    output logic                   irq,
    output logic                   sleep_enable
);
    import uies_pkg::*;

    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    ////////////////////////////////////////////////////////////////////////
    // Control registers.

    uies_data_t  mask_reg;
    uies_data_t  enh_reg;
    logic        fifo_en_reg;
    logic        rd_hold;
    logic        rd_src;
    logic        rd_line;
    logic        rd_modem;
    logic        wr_hold;

    assign rd_hold  = rd_stb && addr == `UIES_OFF_RX_HOLD;
    assign rd_src   = rd_stb && addr == `UIES_OFF_INT_SOURCE;
    assign rd_line  = rd_stb && addr == `UIES_OFF_LINE_STATUS;
    assign rd_modem = rd_stb && addr == `UIES_OFF_MODEM_STAT;
    assign wr_hold  = wr_stb && addr == `UIES_OFF_TX_HOLD;

    logic enh_on;
    assign enh_on = enh_reg[`UIES_ENH_ENABLE_BIT];

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            mask_reg <= `UIES_MASK_RST;
        end else if (wr_stb && addr == `UIES_OFF_INT_MASK) begin
            mask_reg[3:0] <= wr_data[3:0];
            if (enh_on) begin
                mask_reg[7:4] <= wr_data[7:4];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            enh_reg     <= 8'h00;
            fifo_en_reg <= 1'b0;
        end else begin
            if (wr_stb && addr == `UIES_OFF_ENH_CTRL) begin
                enh_reg <= wr_data;
            end
            if (wr_stb && addr == `UIES_OFF_FIFO_CTRL) begin
                fifo_en_reg <= wr_data[`UIES_FIFO_EN_BIT];
            end
        end
    end

    assign sleep_enable = mask_reg[4];

    ////////////////////////////////////////////////////////////////////////
    // Line status flags.

    logic       ready_reg;
    logic       overrun_reg;
    logic [2:0] head_err;
    logic [7:0] line_status;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ready_reg <= 1'b0;
        end else if (rx_char_in) begin
            ready_reg <= 1'b1;
        end else if (rx_fifo_empty) begin
            ready_reg <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            overrun_reg <= 1'b0;
        end else if (rx_overrun) begin
            overrun_reg <= 1'b1;
        end else if (rd_line) begin
            overrun_reg <= 1'b0;
        end
    end

    assign head_err = ready_reg ? rx_head_error : 3'h0;
    assign line_status = {rx_any_error, tx_all_empty && tx_hold_empty,
                          tx_hold_empty, head_err, overrun_reg,
                          ready_reg};

    ////////////////////////////////////////////////////////////////////////
    // Pending sources.

    logic line_pend;
    logic rx_pend;
    logic tout_reg;
    logic tx_reg;
    logic modem_pend;
    logic xoff_reg;
    logic spec_reg;
    logic flow_reg;
    logic tx_cond;
    logic tx_cond_q;
    logic tx_en_q;
    logic cts_q;
    logic rts_q;
    logic [7:0] tout_cnt;
    uies_level_e src_level;
    logic [5:0]  src_code;

    assign line_pend  = mask_reg[2] && (overrun_reg || head_err != 3'h0);
    assign rx_pend    = mask_reg[0] && (fifo_en_reg ? rx_at_trigger
                                                    : ready_reg);
    assign modem_pend = mask_reg[3] && modem_delta != 4'h0;
    assign tx_cond    = fifo_en_reg ? (tx_below_trigger || tx_all_empty)
                                    : tx_hold_empty;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            tx_cond_q <= 1'b0;
            tx_en_q   <= 1'b0;
            cts_q     <= 1'b0;
            rts_q     <= 1'b0;
        end else begin
            tx_cond_q <= tx_cond;
            tx_en_q   <= mask_reg[1];
            cts_q     <= cts_level;
            rts_q     <= rts_level;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            tx_reg <= 1'b0;
        end else if (mask_reg[1] && tx_cond &&
                     (!tx_cond_q || !tx_en_q)) begin
            tx_reg <= 1'b1;
        end else if (rd_src && src_level == UIES_LVL_TX_READY || wr_hold
                     || !mask_reg[1]) begin
            tx_reg <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            tout_cnt <= 8'h00;
            tout_reg <= 1'b0;
        end else if (rx_char_in || rd_hold || ready_reg == 1'b0) begin
            tout_cnt <= 8'h00;
            if (rd_hold) begin
                tout_reg <= 1'b0;
            end
        end else if (bit_tick && fifo_en_reg && mask_reg[0]) begin
            if (tout_cnt == 8'(`UIES_TOUT_BITS - 1)) begin
                tout_reg <= 1'b1;
            end else begin
                tout_cnt <= tout_cnt + 8'h01;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            xoff_reg <= 1'b0;
            spec_reg <= 1'b0;
        end else begin
            if (enh_on && mask_reg[5] && xoff_match) begin
                xoff_reg <= 1'b1;
            end else if (rd_src && src_level == UIES_LVL_XOFF || xon_match) begin
                xoff_reg <= 1'b0;
            end
            if (enh_on && mask_reg[5] && special_match) begin
                spec_reg <= 1'b1;
            end else if (rd_src && src_level == UIES_LVL_XOFF || rx_char_in) begin
                spec_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            flow_reg <= 1'b0;
        end else if (enh_on && ((mask_reg[7] && enh_reg[7] && cts_level && !cts_q)
                  || (mask_reg[6] && enh_reg[6] && rts_level && !rts_q))) begin
            flow_reg <= 1'b1;
        end else if (rd_modem) begin
            flow_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Priority encode.

    always_comb begin
        if (line_pend) begin
            src_level = UIES_LVL_LINE;
        end else if (tout_reg) begin
            src_level = UIES_LVL_TOUT;
        end else if (rx_pend) begin
            src_level = UIES_LVL_RX_READY;
        end else if (tx_reg) begin
            src_level = UIES_LVL_TX_READY;
        end else if (modem_pend) begin
            src_level = UIES_LVL_MODEM;
        end else if (xoff_reg || spec_reg) begin
            src_level = UIES_LVL_XOFF;
        end else if (flow_reg) begin
            src_level = UIES_LVL_FLOW;
        end else begin
            src_level = UIES_LVL_NONE;
        end
    end

    always_comb begin
        case (src_level)
            UIES_LVL_LINE:     src_code = `UIES_CODE_LINE;
            UIES_LVL_TOUT:     src_code = `UIES_CODE_TOUT;
            UIES_LVL_RX_READY: src_code = `UIES_CODE_RX_READY;
            UIES_LVL_TX_READY: src_code = `UIES_CODE_TX_READY;
            UIES_LVL_MODEM:    src_code = `UIES_CODE_MODEM;
            UIES_LVL_XOFF:     src_code = `UIES_CODE_XOFF;
            UIES_LVL_FLOW:     src_code = `UIES_CODE_FLOW;
            default:           src_code = `UIES_SRC_NONE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Read port and request.

    uies_data_t rd_next;

    always_comb begin
        case (addr)
            `UIES_OFF_INT_MASK:    rd_next = mask_reg;
            `UIES_OFF_INT_SOURCE:  rd_next = {{2{fifo_en_reg}}, src_code};
            `UIES_OFF_ENH_CTRL:    rd_next = enh_reg;
            `UIES_OFF_LINE_STATUS: rd_next = line_status;
            `UIES_OFF_MODEM_STAT:  rd_next = {modem_inputs, modem_delta};
            default:               rd_next = 8'h00;
        endcase
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rd_data <= 8'h00;
        end else begin
            rd_data <= rd_stb ? rd_next : 8'h00;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            irq <= 1'b0;
        end else begin
            irq <= src_level != UIES_LVL_NONE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    chk_mask_upper_lock: assert property (
        wr_stb && addr == `UIES_OFF_INT_MASK && !enh_on
        |=> mask_reg[7:4] == $past(mask_reg[7:4]))
        else $error("Upper mask bits changed without enhanced enable.");

    chk_ready_set: assert property (
        rx_char_in |=> line_status[0])
        else $error("Data ready flag not set after character.");

    chk_irq_follows: assert property (
        src_level != UIES_LVL_NONE |=> irq)
        else $error("Request not raised for pending source.");

    chk_src_bit0: assert property (
        rd_src |=> rd_data[0] == !$past(line_pend || tout_reg || rx_pend
                                        || tx_reg || modem_pend || xoff_reg
                                        || spec_reg || flow_reg))
        else $error("Source bit 0 inconsistent with pending state.");

    chk_fifo_bits: assert property (
        rd_src |=> rd_data[7:6] == {2{$past(fifo_en_reg)}})
        else $error("Source bits 7:6 do not follow FIFO enable.");

    chk_line_prio: assert property (
        rd_src && line_pend |=> rd_data[5:0] == `UIES_CODE_LINE)
        else $error("Line status not reported first.");

    chk_modem_prio: assert property (
        rd_src && modem_pend && !line_pend && !tout_reg && !rx_pend
        && !tx_reg |=> rd_data[5:0] == `UIES_CODE_MODEM)
        else $error("Modem status not reported at its level.");

    chk_tx_enable: assert property (
        $rose(mask_reg[1]) && tx_cond |=> tx_reg)
        else $error("Transmit ready not raised when enabled while empty.");

    chk_tx_clear: assert property (
        wr_hold && !(mask_reg[1] && tx_cond
                     && !$past(tx_cond && mask_reg[1])) |=> !tx_reg)
        else $error("Transmit ready not cleared by holding write.");

    chk_xoff_clear: assert property (
        xon_match && !(enh_on && mask_reg[5] && xoff_match) |=> !xoff_reg)
        else $error("Xoff interrupt not cleared by Xon.");

    chk_spec_clear: assert property (
        rx_char_in && !(enh_on && mask_reg[5] && special_match)
        |=> !spec_reg)
        else $error("Special character interrupt not cleared by next char.");

    chk_flow_gate: assert property (
        !enh_on && !flow_reg |=> !flow_reg)
        else $error("Flow interrupt raised without enhanced enable.");

    chk_flow_clear: assert property (
        rd_modem && !(cts_level && !cts_q) && !(rts_level && !rts_q)
        |=> !flow_reg)
        else $error("Flow interrupt not cleared by modem read.");

    chk_tout_clear: assert property (
        rd_hold |=> !tout_reg)
        else $error("Time-out not cleared by receive read.");

    cov_line:  cover property (@(posedge clock) line_pend ##1 rd_line);
    cov_tx:    cover property (@(posedge clock) !tx_reg ##1 tx_reg);
    cov_tout:  cover property (@(posedge clock) !tout_reg ##1 tout_reg);
    cov_flow:  cover property (@(posedge clock) flow_reg ##1 rd_modem);

endmodule : uies_core
`default_nettype wire

// >>> logic/uies_defs.svh
`ifndef UIES_DEFS_SVH
`define UIES_DEFS_SVH

// Register offsets on the three-bit channel register port.
`define UIES_OFF_RX_HOLD     3'h0
`define UIES_OFF_TX_HOLD     3'h0
`define UIES_OFF_INT_MASK    3'h1
`define UIES_OFF_INT_SOURCE  3'h2
`define UIES_OFF_FIFO_CTRL   3'h2
`define UIES_OFF_ENH_CTRL    3'h3
`define UIES_OFF_LINE_STATUS 3'h5
`define UIES_OFF_MODEM_STAT  3'h6

// Reset values.
`define UIES_MASK_RST        8'h00
`define UIES_SRC_NONE        6'h01

// Source codes in interrupt source bits 5..0.
`define UIES_CODE_LINE       6'h06
`define UIES_CODE_TOUT       6'h0c
`define UIES_CODE_RX_READY   6'h04
`define UIES_CODE_TX_READY   6'h02
`define UIES_CODE_MODEM      6'h00
`define UIES_CODE_XOFF       6'h10
`define UIES_CODE_FLOW       6'h20

// Field positions.
`define UIES_ENH_ENABLE_BIT  4
`define UIES_FIFO_EN_BIT     0

// Receive time-out: four characters plus twelve bit times, in bit times.
`define UIES_CHAR_BITS       10
`define UIES_TOUT_BITS       (4 * `UIES_CHAR_BITS + 12)

`endif

// >>> logic/uies_pkg.sv
package uies_pkg;

    typedef logic [2:0] uies_addr_t;
    typedef logic [7:0] uies_data_t;

    typedef enum logic [2:0] {
        UIES_LVL_NONE,
        UIES_LVL_LINE,
        UIES_LVL_TOUT,
        UIES_LVL_RX_READY,
        UIES_LVL_TX_READY,
        UIES_LVL_MODEM,
        UIES_LVL_XOFF,
        UIES_LVL_FLOW
    } uies_level_e;

endpackage : uies_pkg

// >>> tb/uart_interrupt_enable_status_tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module uart_interrupt_enable_status_tb_top;
    import uies_pkg::*;

    logic       clock;
    logic       sys_rst;
    uies_addr_t addr;
    uies_data_t wr_data;
    logic       wr_stb;
    logic       rd_stb;
    uies_data_t rd_data;
    logic       rx_char_in;
    logic       rx_fifo_empty;
    logic       rx_at_trigger;
    logic       rx_overrun;
    logic [2:0] rx_head_error;
    logic       rx_any_error;
    logic       tx_hold_empty;
    logic       tx_below_trigger;
    logic       tx_all_empty;
    logic [3:0] modem_delta;
    logic [3:0] modem_inputs;
    logic       bit_tick;
    logic       xoff_match;
    logic       xon_match;
    logic       special_match;
    logic       cts_level;
    logic       rts_level;
    logic       irq;
    logic       sleep_enable;
    int         n_mismatch;
    int         compares;
    uies_data_t junk;

    uies_core i_dut (.clock, .sys_rst, .addr, .wr_data, .wr_stb, .rd_stb,
        .rd_data, .rx_char_in, .rx_fifo_empty, .rx_at_trigger, .rx_overrun,
        .rx_head_error, .rx_any_error, .tx_hold_empty, .tx_below_trigger,
        .tx_all_empty, .modem_delta, .modem_inputs, .bit_tick, .xoff_match,
        .xon_match, .special_match, .cts_level, .rts_level, .irq,
        .sleep_enable);

    uies_host_model i_host (.clock, .addr, .wr_data, .wr_stb, .rd_stb,
        .rd_data);

    ////////////////////////////////////////////////////////////////////////

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    initial begin
        repeat (5000) @(posedge clock);
        n_mismatch++;
        stop_test();
    end

    ////////////////////////////////////////////////////////////////////////

    task automatic step(input int n);
        repeat (n) @(posedge clock);
    endtask : step

    task automatic ticks(input int n);
        repeat (n) begin
            bit_tick <= 1'b1;
            step(1);
            bit_tick <= 1'b0;
            step(1);
        end
    endtask : ticks

    task automatic chk(input string nm, input uies_data_t e,
                       input uies_data_t g);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic rchk(input uies_addr_t a, input uies_data_t e,
                        input string nm);
        uies_data_t d;
        i_host.rd(a, d);
        chk(nm, e, d);
    endtask : rchk

    task automatic stop_test();
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : stop_test

    ////////////////////////////////////////////////////////////////////////

    initial begin
        n_mismatch = 0;
        compares = 0;
        sys_rst = 1'b1;
        {rx_char_in, rx_at_trigger, rx_overrun, rx_any_error} = 4'h0;
        {tx_hold_empty, tx_below_trigger, tx_all_empty} = 3'h0;
        {bit_tick, xoff_match, xon_match, special_match} = 4'h0;
        {cts_level, rts_level} = 2'h0;
        rx_fifo_empty = 1'b1;
        rx_head_error = 3'h0;
        modem_delta = 4'h0;
        modem_inputs = 4'h5;
        step(2);
        sys_rst <= 1'b0;
        rchk(3'h1, 8'h00, "mask reset");
        rchk(3'h2, 8'h01, "source reset");
        i_host.wr(3'h1, 8'hff);
        rchk(3'h1, 8'h0f, "mask locked");
        i_host.wr(3'h3, 8'h10);
        i_host.wr(3'h1, 8'hf0);
        rchk(3'h1, 8'hf0, "mask open");
        chk("sleep", 8'h01, {7'h0, sleep_enable});
        i_host.wr(3'h1, 8'h00);
        rx_char_in <= 1'b1;
        rx_fifo_empty <= 1'b0;
        rx_head_error <= 3'h5;
        {tx_hold_empty, tx_all_empty, rx_any_error} <= 3'h7;
        step(1);
        rx_char_in <= 1'b0;
        step(2);
        rchk(3'h5, 8'hf5, "line status");
        rx_head_error <= 3'h0;
        {tx_hold_empty, tx_all_empty, rx_any_error} <= 3'h0;
        i_host.wr(3'h2, 8'h01);
        rchk(3'h2, 8'hc1, "fifo on");
        i_host.wr(3'h1, 8'h0f);
        rx_at_trigger <= 1'b1;
        tx_below_trigger <= 1'b1;
        step(3);
        rchk(3'h2, 8'hc4, "rx first");
        chk("irq set", 8'h01, {7'h0, irq});
        rx_overrun <= 1'b1;
        step(1);
        rx_overrun <= 1'b0;
        step(3);
        rchk(3'h2, 8'hc6, "line first");
        rchk(3'h5, 8'h03, "overrun");
        rchk(3'h2, 8'hc4, "line cleared");
        rx_at_trigger <= 1'b0;
        tx_below_trigger <= 1'b0;
        step(3);
        rchk(3'h2, 8'hc2, "tx ready");
        rchk(3'h2, 8'hc1, "tx cleared");
        tx_below_trigger <= 1'b1;
        step(3);
        chk("irq tx", 8'h01, {7'h0, irq});
        i_host.wr(3'h0, 8'h55);
        rchk(3'h2, 8'hc1, "tx write clear");
        modem_delta <= 4'h2;
        step(3);
        rchk(3'h2, 8'hc0, "modem");
        modem_delta <= 4'h0;
        i_host.rd(3'h6, junk);
        rchk(3'h2, 8'hc1, "modem cleared");
        i_host.wr(3'h1, 8'h01);
        ticks(51);
        rchk(3'h2, 8'hc1, "time-out early");
        ticks(1);
        rchk(3'h2, 8'hcc, "time-out");
        i_host.rd(3'h0, junk);
        rchk(3'h2, 8'hc1, "time-out cleared");
        rx_fifo_empty <= 1'b1;
        i_host.wr(3'h1, 8'h20);
        xoff_match <= 1'b1;
        step(1);
        xoff_match <= 1'b0;
        step(3);
        rchk(3'h2, 8'hd0, "xoff");
        rchk(3'h2, 8'hc1, "xoff cleared");
        xoff_match <= 1'b1;
        step(1);
        xoff_match <= 1'b0;
        xon_match <= 1'b1;
        step(1);
        xon_match <= 1'b0;
        step(2);
        rchk(3'h2, 8'hc1, "xon clear");
        special_match <= 1'b1;
        step(1);
        special_match <= 1'b0;
        step(2);
        rchk(3'h2, 8'hd0, "special");
        special_match <= 1'b1;
        step(1);
        special_match <= 1'b0;
        rx_char_in <= 1'b1;
        step(1);
        rx_char_in <= 1'b0;
        step(2);
        rchk(3'h2, 8'hc1, "special next char");
        i_host.wr(3'h3, 8'h90);
        i_host.wr(3'h1, 8'h80);
        cts_level <= 1'b1;
        step(3);
        rchk(3'h2, 8'he0, "flow");
        i_host.rd(3'h6, junk);
        rchk(3'h2, 8'hc1, "flow cleared");
        i_host.wr(3'h3, 8'h50);
        i_host.wr(3'h1, 8'h40);
        rts_level <= 1'b1;
        step(3);
        rchk(3'h2, 8'he0, "rts flow");
        i_host.rd(3'h6, junk);
        rchk(3'h2, 8'hc1, "rts cleared");
        step(2);
        chk("irq clear", 8'h00, {7'h0, irq});
        i_host.wr(3'h1, 8'h20);
        i_host.wr(3'h3, 8'h00);
        xoff_match <= 1'b1;
        step(1);
        xoff_match <= 1'b0;
        step(3);
        rchk(3'h2, 8'hc1, "xoff gated");
        i_host.wr(3'h2, 8'h00);
        i_host.wr(3'h1, 8'h01);
        rx_char_in <= 1'b1;
        rx_fifo_empty <= 1'b0;
        step(1);
        rx_char_in <= 1'b0;
        step(2);
        rchk(3'h2, 8'h04, "rx no fifo");
        stop_test();
    end

endmodule : uart_interrupt_enable_status_tb_top

`default_nettype wire

// >>> tb/uies_host_model.sv
`timescale 1ns/10ps
`default_nettype none

// Host processor on the channel register port.
module uies_host_model (
    input  wire logic                 clock,
    output var  uies_pkg::uies_addr_t addr,
    output var  uies_pkg::uies_data_t wr_data,
    output var  logic                 wr_stb,
    output var  logic                 rd_stb,
    input  wire uies_pkg::uies_data_t rd_data
);
    import uies_pkg::*;

    initial begin
        addr    = 3'h0;
        wr_data = 8'h00;
        wr_stb  = 1'b0;
        rd_stb  = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////

    // A write is one strobe cycle; the data bus is scrambled afterwards.
    task automatic wr(input uies_addr_t a, input uies_data_t d);
        @(posedge clock);
        addr    <= a;
        wr_data <= d;
        wr_stb  <= 1'b1;
        @(posedge clock);
        wr_stb  <= 1'b0;
        wr_data <= ~d;
    endtask : wr

    // Read data stand only in the cycle after the strobe.
    task automatic rd(input uies_addr_t a, output uies_data_t d);
        @(posedge clock);
        addr   <= a;
        rd_stb <= 1'b1;
        @(posedge clock);
        rd_stb <= 1'b0;
        #1;
        d = rd_data;
    endtask : rd

endmodule : uies_host_model

`default_nettype wire
